// ===== include/retimer_channel_consts.vh
// Offsets, fields, reset values and steps of the channel control slice
`ifndef RETIMER_CHANNEL_CONSTS_VH
`define RETIMER_CHANNEL_CONSTS_VH
`define ADDR_CHANNEL_SELECT 8'hff
`define ADDR_OVERRIDE_ENABLES 8'h09
`define ADDR_RECOVERY_RESET_OVERRIDE 8'h0a
`define ADDR_CAP_START_GROUP_B 8'h0b
`define ADDR_LOCK_QUALIFY_CONTROL 8'h0c
`define ADDR_PATTERN_SHIFT_CONTROL 8'h0d
`define ADDR_RESERVED_CFG_E 8'h0e
`define ADDR_RESERVED_CFG_F 8'h0f
`define ADDR_RESERVED_CFG_10 8'h10
`define ADDR_EYE_MONITOR_TAP_POLARITY 8'h11
`define ADDR_FIRST_TAP_CONTROL 8'h12
`define ADDR_OFFSET_BOOST_MODE 8'h13
`define ADDR_SIGNAL_DETECT_CONTROL 8'h14
`define RST_OVERRIDE_ENABLES 8'h00
`define RST_RECOVERY_RESET_OVERRIDE 8'h10
`define RST_CAP_START_GROUP_B 8'h0f
`define RST_LOCK_QUALIFY_CONTROL 8'h08
`define RST_PATTERN_SHIFT_CONTROL 8'h00
`define RST_RESERVED_CFG_E 8'h93
`define RST_RESERVED_CFG_F 8'h69
`define RST_RESERVED_CFG_10 8'h3a
`define RST_EYE_MONITOR_TAP_POLARITY 8'h20
`define RST_FIRST_TAP_CONTROL 8'ha0
`define RST_OFFSET_BOOST_MODE 8'h90
`define RST_SIGNAL_DETECT_CONTROL 8'h00
`define RST_CHANNEL_SELECT 8'h00
`define BIT_OUTPUT_MUX_OVERRIDE 5
`define BIT_DIVIDER_OVERRIDE 2
`define BIT_RECOVERY_RESET_OVERRIDE_EN 3
`define BIT_RECOVERY_RESET_VALUE 2
`define BIT_SINGLE_BIT_TRANSITION_CHECK 3
`define BIT_PATTERN_SHIFT_ENABLE 5
`define BIT_EYE_MONITOR_POWER_DOWN 5
`define BIT_TAP1_POLARITY 7
`define BIT_NEGATIVE_GM 5
`define BIT_DC_OFFSET_ENABLE 4
`define BIT_BOOST_LIMIT 2
`define BIT_WAVELENGTH_MODE 1
`define BIT_FORCE_DETECT_ON 7
`define BIT_FORCE_DETECT_OFF 6
`define EYE_STEP_UV_PER_CODE 16'd3125
`endif

// ===== verilog/signal_detect_resolve.v
// Signal-detect force and threshold resolution for one channel
`include "retimer_channel_consts.vh"
module signal_detect_resolve
(
	input wire [7:0] control,
	input wire raw_detect,
	output wire detect,
	output wire [1:0] assert_level,
	output wire [1:0] deassert_level
);
	// Force-off wins when both forces are set
	assign detect = control[`BIT_FORCE_DETECT_OFF] ? 1'b0 :
		(control[`BIT_FORCE_DETECT_ON] ? 1'b1 : raw_detect);
	assign assert_level = control[5:4];
	assign deassert_level = control[3:2];
endmodule // signal_detect_resolve

// ===== verilog/retimer_channel_control_regs.v
// Per-channel control register slice of a two-channel retimer
// Functional notes
// - Accesses go to the set chosen by channel select; choice holds until rewritten.
// - Output mux override bit picks manual mux field, else automatic selection.
// - Divider override bit applies manual VCO divider ratio, else automatic.
// - Recovery reset override enable drives reset from the override value bit.
// - Override value bit gives the recovery reset level; resets to zero.
// - Second search group starting capacitor code in five bits, reset 0x0f.
// - Single-bit-transition lock qualification enable, resets to one.
// - Two-bit eye monitor step: 3.125 mV per code step, from 3.125 mV.
// - Eye monitor power-down bit, resets to one.
// - Tap 2 to 5 polarities apply only under manual tap override.
// - Tap 1 polarity and weight apply under manual override; reset 0xa0.
// - Negative transconductance select for feedback equaliser, resets to one.
// - DC offset loop enable resets to one; wavelength-division mode bit.
// - Extra limiting bit of fourth boost stage, resets to zero.
// - Force-on reports signal detect asserted whatever the input, unless force-off is also set.
// - Force-off reports signal detect deasserted whatever the input.
// - Assert and deassert threshold fields, both reset to zero.
`include "retimer_channel_consts.vh"
module retimer_channel_control_regs
#(
	parameter CHANNELS = 2,
	parameter REGS = 12
)
(
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	input wire [CHANNELS*2-1:0] auto_output_mux,
	input wire [CHANNELS*3-1:0] auto_divider,
	input wire [CHANNELS-1:0] internal_recovery_reset,
	input wire [CHANNELS-1:0] manual_tap_override,
	input wire [CHANNELS-1:0] raw_signal_detect,
	input wire [CHANNELS*3-1:0] manual_output_mux,
	input wire [CHANNELS*3-1:0] manual_divider,
	output wire [CHANNELS*3-1:0] output_mux_select,
	output wire [CHANNELS*3-1:0] divider_select,
	output wire [CHANNELS-1:0] recovery_reset,
	output wire [CHANNELS*5-1:0] cap_start_code,
	output wire [CHANNELS-1:0] single_bit_transition_check,
	output wire [CHANNELS-1:0] pattern_shift_enable,
	output wire [CHANNELS*16-1:0] eye_step_uv,
	output wire [CHANNELS-1:0] eye_monitor_power_down,
	output wire [CHANNELS*5-1:0] tap_polarity,
	output wire [CHANNELS*5-1:0] tap1_weight,
	output wire [CHANNELS-1:0] tap_manual_apply,
	output wire [CHANNELS-1:0] negative_gm,
	output wire [CHANNELS-1:0] dc_offset_enable,
	output wire [CHANNELS-1:0] boost_limit,
	output wire [CHANNELS-1:0] wavelength_mode,
	output wire [CHANNELS-1:0] signal_detect,
	output wire [CHANNELS*2-1:0] detect_assert_level,
	output wire [CHANNELS*2-1:0] detect_deassert_level
);
	// ****************************************************************
	// Address decode
	// ****************************************************************
	function [4:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
				`ADDR_OVERRIDE_ENABLES: reg_index = 5'h00;
				`ADDR_RECOVERY_RESET_OVERRIDE: reg_index = 5'h01;
				`ADDR_CAP_START_GROUP_B: reg_index = 5'h02;
				`ADDR_LOCK_QUALIFY_CONTROL: reg_index = 5'h03;
				`ADDR_PATTERN_SHIFT_CONTROL: reg_index = 5'h04;
				`ADDR_RESERVED_CFG_E: reg_index = 5'h05;
				`ADDR_RESERVED_CFG_F: reg_index = 5'h06;
				`ADDR_RESERVED_CFG_10: reg_index = 5'h07;
				`ADDR_EYE_MONITOR_TAP_POLARITY: reg_index = 5'h08;
				`ADDR_FIRST_TAP_CONTROL: reg_index = 5'h09;
				`ADDR_OFFSET_BOOST_MODE: reg_index = 5'h0a;
				`ADDR_SIGNAL_DETECT_CONTROL: reg_index = 5'h0b;
				default: reg_index = 5'h1f;
			endcase
		end
	endfunction

	function [7:0] reset_value;
		input [4:0] idx;
		begin
			case (idx)
				5'h00: reset_value = `RST_OVERRIDE_ENABLES;
				5'h01: reset_value = `RST_RECOVERY_RESET_OVERRIDE;
				5'h02: reset_value = `RST_CAP_START_GROUP_B;
				5'h03: reset_value = `RST_LOCK_QUALIFY_CONTROL;
				5'h04: reset_value = `RST_PATTERN_SHIFT_CONTROL;
				5'h05: reset_value = `RST_RESERVED_CFG_E;
				5'h06: reset_value = `RST_RESERVED_CFG_F;
				5'h07: reset_value = `RST_RESERVED_CFG_10;
				5'h08: reset_value = `RST_EYE_MONITOR_TAP_POLARITY;
				5'h09: reset_value = `RST_FIRST_TAP_CONTROL;
				5'h0a: reset_value = `RST_OFFSET_BOOST_MODE;
				5'h0b: reset_value = `RST_SIGNAL_DETECT_CONTROL;
				default: reset_value = 8'h00;
			endcase
		end
	endfunction

	function [15:0] eye_step;
		input [1:0] code;
		begin
			case (code)
				2'b00: eye_step = `EYE_STEP_UV_PER_CODE;
				2'b01: eye_step = `EYE_STEP_UV_PER_CODE * 16'd2;
				2'b10: eye_step = `EYE_STEP_UV_PER_CODE * 16'd3;
				2'b11: eye_step = `EYE_STEP_UV_PER_CODE * 16'd4;
				default: eye_step = `EYE_STEP_UV_PER_CODE;
			endcase
		end
	endfunction

	reg [7:0] channel_select;
	reg [7:0] bank [0:CHANNELS*REGS-1];
	wire [4:0] access_index;
	wire [1:0] access_channel;
	wire select_hit;
	wire bank_hit;
	wire select_write;
	wire bank_write;

	assign access_index = reg_index(reg_addr);
	// Low bit of the select names the channel
	assign access_channel = {1'b0, channel_select[0]};
	assign select_hit = (reg_addr == `ADDR_CHANNEL_SELECT);
	assign bank_hit = (access_index != 5'h1f);
	assign select_write = reg_write && select_hit;
	assign bank_write = reg_write && bank_hit;

	// ****************************************************************
	// Channel select and register storage
	// ****************************************************************
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			channel_select <= `RST_CHANNEL_SELECT;
		else if (select_write)
			channel_select <= reg_wdata;
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS*REGS; g = g + 1)
		begin : storage
			localparam [4:0] slot = g % REGS;
			always @(posedge sys_clk)
			begin
				if (!reset_n)
					bank[g] <= reset_value(slot);
				else if (bank_write && (access_channel * REGS + access_index == g))
					bank[g] <= reg_wdata;
			end
		end
	endgenerate

	// ****************************************************************
	// Read path
	// ****************************************************************
	reg [7:0] read_value;

	always @*
	begin
		read_value = 8'h00;
		if (select_hit)
			read_value = channel_select;
		else if (bank_hit)
			read_value = bank[access_channel * REGS + access_index];
	end

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_read;
			if (reg_read)
			begin
				reg_rdata <= read_value;
			end
		end
	end

	// ****************************************************************
	// Per-channel field decode
	// ****************************************************************
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : channel
			wire [7:0] ovr;
			wire [7:0] rst_ovr;
			wire [7:0] cap;
			wire [7:0] lockq;
			wire [7:0] pat;
			wire [7:0] eye;
			wire [7:0] tap1;
			wire [7:0] obm;
			wire [7:0] sdc;
			reg [2:0] mux_choice;
			reg [2:0] divider_choice;
			reg reset_choice;
			reg [4:0] polarity_choice;
			reg [4:0] weight_choice;

			assign ovr = bank[g*REGS + 0];
			assign rst_ovr = bank[g*REGS + 1];
			assign cap = bank[g*REGS + 2];
			assign lockq = bank[g*REGS + 3];
			assign pat = bank[g*REGS + 4];
			assign eye = bank[g*REGS + 8];
			assign tap1 = bank[g*REGS + 9];
			assign obm = bank[g*REGS + 10];
			assign sdc = bank[g*REGS + 11];

			// ****************************************************************
			// Override selection
			// ****************************************************************
			always @*
			begin
				if (ovr[`BIT_OUTPUT_MUX_OVERRIDE])
					mux_choice = manual_output_mux[g*3 +: 3];
				else
					mux_choice = {1'b0, auto_output_mux[g*2 +: 2]};
			end

			always @*
			begin
				if (ovr[`BIT_DIVIDER_OVERRIDE])
					divider_choice = manual_divider[g*3 +: 3];
				else
					divider_choice = auto_divider[g*3 +: 3];
			end

			always @*
			begin
				if (rst_ovr[`BIT_RECOVERY_RESET_OVERRIDE_EN])
					reset_choice = rst_ovr[`BIT_RECOVERY_RESET_VALUE];
				else
					reset_choice = internal_recovery_reset[g];
			end

			assign output_mux_select[g*3 +: 3] = mux_choice;
			assign divider_select[g*3 +: 3] = divider_choice;
			assign recovery_reset[g] = reset_choice;

			// ****************************************************************
			// Tap gating
			// ****************************************************************
			// Bit 0 tap 1, bits 4:1 taps 2 to 5; zero unless manual
			always @*
			begin
				if (manual_tap_override[g])
				begin
					polarity_choice = {eye[0], eye[1], eye[2], eye[3], tap1[`BIT_TAP1_POLARITY]};
					weight_choice = tap1[4:0];
				end
				else
				begin
					polarity_choice = 5'h00;
					weight_choice = 5'h00;
				end
			end

			assign tap_polarity[g*5 +: 5] = polarity_choice;
			assign tap1_weight[g*5 +: 5] = weight_choice;
			assign tap_manual_apply[g] = manual_tap_override[g];

			// ****************************************************************
			// Direct fields
			// ****************************************************************
			assign cap_start_code[g*5 +: 5] = cap[4:0];
			assign single_bit_transition_check[g] = lockq[`BIT_SINGLE_BIT_TRANSITION_CHECK];
			// Ordering with companion enables is up to software
			assign pattern_shift_enable[g] = pat[`BIT_PATTERN_SHIFT_ENABLE];
			// Step size in microvolts
			assign eye_step_uv[g*16 +: 16] = eye_step(eye[7:6]);
			assign eye_monitor_power_down[g] = eye[`BIT_EYE_MONITOR_POWER_DOWN];
			assign negative_gm[g] = tap1[`BIT_NEGATIVE_GM];
			assign dc_offset_enable[g] = obm[`BIT_DC_OFFSET_ENABLE];
			assign wavelength_mode[g] = obm[`BIT_WAVELENGTH_MODE];
			assign boost_limit[g] = obm[`BIT_BOOST_LIMIT];

			signal_detect_resolve detect_unit
			(
				.control(sdc),
				.raw_detect(raw_signal_detect[g]),
				.detect(signal_detect[g]),
				.assert_level(detect_assert_level[g*2 +: 2]),
				.deassert_level(detect_deassert_level[g*2 +: 2])
			);
		end
	endgenerate
endmodule // retimer_channel_control_regs

// ===== tb/retimer_channel_checker.sv
// Port-level assertions for the channel control register slice
module retimer_channel_checker
#(
	parameter CHANNELS = 2
)
(
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire reg_rvalid,
	input wire [CHANNELS-1:0] manual_tap_override,
	input wire [CHANNELS*5-1:0] tap_polarity,
	input wire [CHANNELS*5-1:0] tap1_weight,
	input wire [CHANNELS-1:0] tap_manual_apply,
	input wire [CHANNELS-1:0] eye_monitor_power_down,
	input wire [CHANNELS-1:0] single_bit_transition_check,
	input wire [CHANNELS-1:0] negative_gm,
	input wire [CHANNELS-1:0] dc_offset_enable,
	input wire [CHANNELS-1:0] boost_limit,
	input wire [CHANNELS*5-1:0] cap_start_code
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence read_answer;
		##1 reg_rvalid;
	endsequence
	read_latency_a: assert property (reg_read |-> read_answer)
		else $error("read answer missing");
	rvalid_pulse_a: assert property (!reg_read |=> !reg_rvalid)
		else $error("stray read valid");
	rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved");
	unmapped_read_a: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	eye_off_reset_a: assert property ($rose(reset_n) |-> &eye_monitor_power_down)
		else $error("eye monitor not powered down after reset");
	check_reset_a: assert property ($rose(reset_n) |-> &single_bit_transition_check)
		else $error("transition check not enabled after reset");
	gm_reset_a: assert property ($rose(reset_n) |-> &negative_gm)
		else $error("negative gm not set after reset");
	offset_reset_a: assert property ($rose(reset_n) |-> &dc_offset_enable && boost_limit == 0)
		else $error("offset or boost limit wrong after reset");
	cap_reset_a: assert property ($rose(reset_n) |-> cap_start_code == {CHANNELS{5'h0f}})
		else $error("capacitor start code wrong after reset");
	tap_apply_a: assert property (tap_manual_apply == manual_tap_override)
		else $error("tap apply differs from override");
	genvar g;
	for (g = 0; g < CHANNELS; g++)
	begin : per_channel
		wire [4:0] pol = tap_polarity[g*5 +: 5];
		wire [4:0] wgt = tap1_weight[g*5 +: 5];
		tap_gate_a: assert property (!manual_tap_override[g] |-> pol == 5'h00 && wgt == 5'h00)
			else $error("tap fields not gated");
	end
endmodule // retimer_channel_checker
bind retimer_channel_control_regs retimer_channel_checker #(.CHANNELS(CHANNELS)) checker_inst (.sys_clk(sys_clk),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.manual_tap_override(manual_tap_override), .tap_polarity(tap_polarity), .tap1_weight(tap1_weight),
	.tap_manual_apply(tap_manual_apply), .eye_monitor_power_down(eye_monitor_power_down),
	.single_bit_transition_check(single_bit_transition_check), .negative_gm(negative_gm),
	.dc_offset_enable(dc_offset_enable), .boost_limit(boost_limit), .cap_start_code(cap_start_code));

// ===== tb/retimer_channel_control_regs_tb.sv
// Self-checking bench for the channel control register slice
module retimer_channel_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, reg_rvalid;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [1:0] irr = 0, mto = 0, rsd = 0, rr, stc, pse, emp, tma, ngm, dco, bl, wm, sd;
	logic [3:0] dal, ddl;
	logic [5:0] oms, dsel;
	logic [9:0] tp, tw, csc;
	logic [31:0] esu;
	logic [7:0] rv [0:11] = '{8'h00, 8'h10, 8'h0f, 8'h08, 8'h00, 8'h93, 8'h69, 8'h3a, 8'h20, 8'ha0, 8'h90, 8'h00};
	int err_count = 0, total_checks = 0;
	retimer_channel_control_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .auto_output_mux(4'h6), .auto_divider(6'o12), .internal_recovery_reset(irr),
		.manual_tap_override(mto), .raw_signal_detect(rsd), .manual_output_mux(6'o54), .manual_divider(6'o73),
		.output_mux_select(oms), .divider_select(dsel), .recovery_reset(rr), .cap_start_code(csc),
		.single_bit_transition_check(stc), .pattern_shift_enable(pse), .eye_step_uv(esu),
		.eye_monitor_power_down(emp), .tap_polarity(tp), .tap1_weight(tw), .tap_manual_apply(tma),
		.negative_gm(ngm), .dc_offset_enable(dco), .boost_limit(bl), .wavelength_mode(wm),
		.signal_detect(sd), .detect_assert_level(dal), .detect_deassert_level(ddl));
	always #2 sys_clk = ~sys_clk;
	task chk(input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task rc(input logic [7:0] a, exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rvalid, 1'b1);
		chk(reg_rdata, exp);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1;
		for (int c = 0; c < 2; c++)
		begin
			wr(8'hff, c[7:0]);
			for (int i = 0; i < 12; i++)
				rc(8'h09 + i[7:0], rv[i]);
		end
		rc(8'h00, 8'h00);
		wr(8'h15, 8'hff);
		rc(8'h15, 8'h00);
		rc(8'hff, 8'h01);
		wr(8'h14, 8'h80);
		chk(sd, 2'b10);
		@(posedge sys_clk) rsd <= 2'b11;
		wr(8'h14, 8'h74);
		chk({sd, dal[3:2], ddl[3:2]}, 6'b01_11_01);
		wr(8'h14, 8'hc0);
		chk(sd, 2'b01);
		wr(8'h09, 8'h24);
		chk({oms[5:3], dsel[5:3]}, 6'o57);
		wr(8'h09, 8'h00);
		chk({oms[5:3], dsel[5:3]}, 6'o11);
		@(posedge sys_clk) irr <= 2'b01;
		wr(8'h0a, 8'h1c);
		chk(rr, 2'b11);
		wr(8'h0a, 8'h18);
		chk(rr, 2'b01);
		@(posedge sys_clk) mto <= 2'b10;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h11, {k[1:0], 6'h0a});
			chk(esu[31:16], 16'd3125 * (k[15:0] + 16'd1));
			chk({emp, tp[9:5]}, 7'b01_01011);
		end
		wr(8'h12, 8'h1f);
		chk({tp[5], ngm[1], tw[9:5]}, 7'h1f);
		wr(8'h13, 8'h06);
		chk({dco[1], bl[1], wm[1]}, 3'b011);
		wr(8'h0c, 8'h00);
		chk(stc, 2'b01);
		wr(8'h0d, 8'h20);
		chk(pse, 2'b10);
		wr(8'h0b, 8'h15);
		chk(csc[9:5], 5'h15);
		chk({tma, tp[4:0], tw[4:0]}, 12'h800);
		wr(8'hff, 8'h02);
		rc(8'hff, 8'h02);
		rc(8'h14, 8'h00);
		chk({sd, dal[1:0]}, 4'b0100);
		end_of_test;
	end
endmodule // retimer_channel_control_regs_tb
